//--- pkg/data_space_pkg.sv
package data_space_pkg;

  localparam int EA_W     = 16;
  localparam int WORD_W   = 16;
  localparam int WREG_N   = 16;
  localparam int WIDX_W   = 4;
  localparam int RAM_WORDS = 1024;
  localparam int RAM_IDX_W = 10;
  localparam int SFR_ADDR_W = 11;
  localparam int PSV_ADDR_W = 15;
  localparam int TBL_ADDR_W = 24;
  localparam int PC_W       = 23;
  localparam int NEAR_FIELD_W = 13;
  localparam int CFG_N      = 7;
  localparam int NVM_IDX_W  = 8;

  // Top effective-address bit that selects the program visibility window.
  localparam int PSV_BIT = 15;

  localparam logic [EA_W-1:0] WREG_TOP      = 16'h001F;
  localparam logic [EA_W-1:0] SFR_TOP       = 16'h07FF;
  localparam logic [EA_W-1:0] RAM_BASE      = 16'h0800;
  localparam logic [EA_W-1:0] RAM_END_BIG   = 16'h0FFF;
  localparam logic [EA_W-1:0] RAM_END_SMALL = 16'h0BFF;
  localparam logic [EA_W-1:0] NEAR_TOP      = 16'h1FFF;

  // One bit per 32-byte block of the register region, indexed by address bits 10:5.
  localparam int SFR_BLOCK_LSB = 5;
  localparam int SFR_BLOCK_MSB = 10;
  localparam logic [63:0] SFR_IMPL_MASK = 64'h0C01_0080_0323_333F;

  localparam logic [WORD_W-1:0] WREG_RESET   = 16'h0000;
  localparam logic [WORD_W-1:0] WREG15_RESET = 16'h0800;

  localparam logic [EA_W-1:0] STEP_BYTE = 16'h0001;
  localparam logic [EA_W-1:0] STEP_WORD = 16'h0002;
  localparam logic [PC_W-1:0] PC_STEP   = 23'h000002;

  localparam logic [TBL_ADDR_W-1:0] NVM_BASE     = 24'h7FFE00;
  localparam logic [TBL_ADDR_W-1:0] NVM_END      = 24'h7FFFFF;
  localparam logic [TBL_ADDR_W-1:0] PROG_SPACE_END = 24'h7FFFFF;
  localparam logic [CFG_N-1:0][TBL_ADDR_W-1:0] CFG_ADDR = {
    24'hF8000E, 24'hF8000C, 24'hF8000A, 24'hF80008, 24'hF80006, 24'hF80004, 24'hF80000
  };

  typedef enum logic [1:0] {
    AGU_INDIRECT,
    AGU_POSTINC,
    AGU_NEAR,
    AGU_FULL
  } agu_mode_e;

  typedef enum logic [2:0] {
    TGT_ZERO,
    TGT_WREG,
    TGT_SFR,
    TGT_RAM,
    TGT_PSV
  } target_e;

  typedef enum logic [1:0] {
    TBL_PROGRAM,
    TBL_NVM,
    TBL_CONFIG,
    TBL_OTHER
  } tbl_kind_e;

endpackage

//--- rtl/address_generator.sv
`timescale 1ns/1ps
module address_generator
  import data_space_pkg::*;
(
  input  wire agu_mode_e         mode,
  input  wire logic              byteOp,
  input  wire logic [EA_W-1:0]   ptrVal,
  input  wire logic [EA_W-1:0]   directAddr,
  output logic      [EA_W-1:0]   ea,
  output logic      [EA_W-1:0]   ptrNext,
  output logic                   ptrWrite
);

  always_comb begin
    ea       = ptrVal;
    ptrWrite = 1'b0;
    case (mode)
      AGU_INDIRECT: ea = ptrVal;
      AGU_POSTINC: begin
        ea       = ptrVal;
        ptrWrite = 1'b1;
      end
      AGU_NEAR: ea = {{(EA_W-NEAR_FIELD_W){1'b0}}, directAddr[NEAR_FIELD_W-1:0]};
      AGU_FULL: ea = directAddr;
      default:  ea = ptrVal;
    endcase
  end

  // Byte steps advance by one, word steps by two.
  assign ptrNext = ptrVal + (byteOp ? STEP_BYTE : STEP_WORD);

endmodule // address_generator

//--- rtl/data_ram.sv
`timescale 1ns/1ps
module data_ram
  import data_space_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 wrEn,
  input  wire logic [1:0]           wrLanes,
  input  wire logic [RAM_IDX_W-1:0] wrIndex,
  input  wire logic [WORD_W-1:0]    wrData,
  input  wire logic [RAM_IDX_W-1:0] rdIndex,
  output logic      [WORD_W-1:0]    rdData_q
);

  // Two byte-wide banks share one word decode but have their own write lines.
  logic [7:0] lowBank  [RAM_WORDS];
  logic [7:0] highBank [RAM_WORDS];

  always_ff @(posedge clk) begin
    if (wrEn && wrLanes[0]) begin
      lowBank[wrIndex] <= wrData[7:0];
    end
    if (wrEn && wrLanes[1]) begin
      highBank[wrIndex] <= wrData[15:8];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData_q <= 16'h0000;
    end else begin
      rdData_q <= {highBank[rdIndex], lowBank[rdIndex]};
    end
  end

endmodule // data_ram

//--- rtl/data_space_access_unit.sv
// What this block does
// - Separate address generators form read and write addresses independently.
// - Effective addresses are 16 bits wide and select bytes.
// - Top address bit zero hits memory; one goes to the visibility window.
// - Memory is 512 or 1024 words; reads outside it return zero.
// - Low byte lives at the even address, high byte at the odd one.
// - Post-increment adds one for bytes, two for words.
// - Byte reads fetch the word, pick by bit zero, return in low byte.
// - Shared word decode with separate byte write lanes.
// - Word access at an odd address is misaligned and raises a trap.
// - Misaligned read completes together with its trap; misaligned write is suppressed and the trap follows.
// - Byte loads into a working register change only its low byte.
// - Sign-extend and zero-extend operations on working registers.
// - Near region 0000h-1FFFh reachable through a 13-bit direct field.
// - Full 16-bit direct address reaches the whole data space.
// - Register region 0000h-07FFh; unused addresses read as zero.
// - Register region decoded in 32-byte blocks with real registers.
// - Nonvolatile store: 256 words at 7FFE00 via table access.
// - Seven configuration words at fixed locations F80000 to F8000E.
// - Program addresses stay even and step by two.
`timescale 1ns/1ps
module data_space_access_unit
  import data_space_pkg::*;
#(
  parameter bit BIG_VARIANT = 1'b1
)
(
  input  wire logic                                 clk,
  input  wire logic                                 reset_n,
  input  wire logic                                 rdReq,
  input  wire logic                                 rdByte,
  input  wire data_space_pkg::agu_mode_e            rdMode,
  input  wire logic [data_space_pkg::WIDX_W-1:0]    rdPtr,
  input  wire logic [data_space_pkg::EA_W-1:0]      rdDirect,
  input  wire logic [data_space_pkg::WIDX_W-1:0]    rdDest,
  input  wire logic                                 wrReq,
  input  wire logic                                 wrByte,
  input  wire data_space_pkg::agu_mode_e            wrMode,
  input  wire logic [data_space_pkg::WIDX_W-1:0]    wrPtr,
  input  wire logic [data_space_pkg::EA_W-1:0]      wrDirect,
  input  wire logic [data_space_pkg::WORD_W-1:0]    wrData,
  input  wire logic                                 extReq,
  input  wire logic                                 extSigned,
  input  wire logic [data_space_pkg::WIDX_W-1:0]    extReg,
  input  wire logic                                 errClear,
  input  wire logic [data_space_pkg::WORD_W-1:0]    sfrRdData,
  input  wire logic [data_space_pkg::WORD_W-1:0]    psvRdData,
  input  wire logic                                 tblReq,
  input  wire logic [data_space_pkg::TBL_ADDR_W-1:0] tblAddr,
  input  wire logic                                 pcAdvance,
  input  wire logic                                 pcLoad,
  input  wire logic [data_space_pkg::PC_W-1:0]      pcValue,
  input  wire logic [data_space_pkg::WIDX_W-1:0]    regViewSel,
  output logic                                      rdValid_q,
  output logic      [data_space_pkg::WORD_W-1:0]    rdData_q,
  output logic                                      addrErrTrap_q,
  output logic                                      addrErrFlag_q,
  output logic      [data_space_pkg::EA_W-1:0]      errAddr_q,
  output logic                                      sfrRdReq_q,
  output logic      [data_space_pkg::SFR_ADDR_W-1:0] sfrRdAddr_q,
  output logic                                      sfrWrReq_q,
  output logic      [data_space_pkg::SFR_ADDR_W-1:0] sfrWrAddr_q,
  output logic      [data_space_pkg::WORD_W-1:0]    sfrWrData_q,
  output logic      [1:0]                           sfrWrLanes_q,
  output logic                                      psvReq_q,
  output logic      [data_space_pkg::PSV_ADDR_W-1:0] psvAddr_q,
  output logic                                      tblValid_q,
  output data_space_pkg::tbl_kind_e                 tblKind_q,
  output logic      [data_space_pkg::NVM_IDX_W-1:0] tblIndex_q,
  output logic      [data_space_pkg::PC_W-1:0]      progAddr_q,
  output logic      [data_space_pkg::WORD_W-1:0]    regView_q
);
  import data_space_pkg::*;

  logic [WORD_W-1:0] wReg_q [WREG_N];

  logic [EA_W-1:0] rdEa;
  logic [EA_W-1:0] rdPtrNext;
  logic            rdPtrWrite;
  logic [EA_W-1:0] wrEa;
  logic [EA_W-1:0] wrPtrNext;
  logic            wrPtrWrite;

  logic            rd1Valid_q;
  target_e         rd1Target_q;
  logic            rd1HighByte_q;
  logic            rd1Byte_q;
  logic            rd1Misalign_q;
  logic [WIDX_W-1:0] rd1Dest_q;
  logic [EA_W-1:0] rd1Ea_q;
  logic [WORD_W-1:0] rd1WregWord_q;

  target_e         rdTarget;
  target_e         wrTarget;
  logic            rdMisalign;
  logic            wrMisalign;
  logic            wrAllowed;
  logic [1:0]      wrLanes;
  logic [WORD_W-1:0] wrWord;
  logic [WORD_W-1:0] rd1Word;
  logic [WORD_W-1:0] rd1Result;
  logic            ramWrEn;

  // Address region decode shared by both generators.
  function automatic target_e decodeTarget(input logic [EA_W-1:0] ea);
    target_e t;
    t = TGT_ZERO;
    if (ea[PSV_BIT]) begin
      t = TGT_PSV;
    end else if (ea <= WREG_TOP) begin
      t = TGT_WREG;
    end else if (ea <= SFR_TOP) begin
      // Blocks with no implemented register answer with zero.
      t = SFR_IMPL_MASK[ea[SFR_BLOCK_MSB:SFR_BLOCK_LSB]] ? TGT_SFR : TGT_ZERO;
    end else if (ea <= (BIG_VARIANT ? RAM_END_BIG : RAM_END_SMALL)) begin
      t = TGT_RAM;
    end else begin
      t = TGT_ZERO;
    end
    return t;
  endfunction

  address_generator readGen (
    .mode       (rdMode),
    .byteOp     (rdByte),
    .ptrVal     (wReg_q[rdPtr]),
    .directAddr (rdDirect),
    .ea         (rdEa),
    .ptrNext    (rdPtrNext),
    .ptrWrite   (rdPtrWrite)
  );

  address_generator writeGen (
    .mode       (wrMode),
    .byteOp     (wrByte),
    .ptrVal     (wReg_q[wrPtr]),
    .directAddr (wrDirect),
    .ea         (wrEa),
    .ptrNext    (wrPtrNext),
    .ptrWrite   (wrPtrWrite)
  );

  assign rdTarget   = decodeTarget(rdEa);
  assign wrTarget   = decodeTarget(wrEa);
  assign rdMisalign = !rdByte && rdEa[0];
  assign wrMisalign = !wrByte && wrEa[0];
  // A misaligned store still runs its instruction but never reaches storage.
  assign wrAllowed  = wrReq && !wrMisalign;

  // Odd byte addresses use the high lane, even ones the low lane.
  assign wrLanes = wrByte ? (wrEa[0] ? 2'b10 : 2'b01) : 2'b11;
  assign wrWord  = wrByte ? {wrData[7:0], wrData[7:0]} : wrData;
  assign ramWrEn = wrAllowed && (wrTarget == TGT_RAM);

  data_ram dataMemory (
    .clk      (clk),
    .reset_n  (reset_n),
    .wrEn     (ramWrEn),
    .wrLanes  (wrLanes),
    .wrIndex  (wrEa[RAM_IDX_W:1]),
    .wrData   (wrWord),
    .rdIndex  (rdEa[RAM_IDX_W:1]),
    .rdData_q (rd1Word)
  );

  // First read stage: the request is decoded and the source addressed.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd1Valid_q    <= 1'b0;
      rd1Target_q   <= TGT_ZERO;
      rd1HighByte_q <= 1'b0;
      rd1Byte_q     <= 1'b0;
      rd1Misalign_q <= 1'b0;
      rd1Dest_q     <= '0;
      rd1Ea_q       <= '0;
      rd1WregWord_q <= '0;
    end else begin
      rd1Valid_q    <= rdReq;
      rd1Target_q   <= rdTarget;
      rd1HighByte_q <= rdEa[0];
      rd1Byte_q     <= rdByte;
      rd1Misalign_q <= rdReq && rdMisalign;
      rd1Dest_q     <= rdDest;
      rd1Ea_q       <= rdEa;
      rd1WregWord_q <= wReg_q[rdEa[WIDX_W:1]];
    end
  end

  // Outside requests to the register region and the visibility window.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sfrRdReq_q <= 1'b0;
      sfrRdAddr_q <= '0;
      psvReq_q   <= 1'b0;
      psvAddr_q  <= '0;
    end else begin
      sfrRdReq_q  <= rdReq && (rdTarget == TGT_SFR);
      sfrRdAddr_q <= {rdEa[SFR_ADDR_W-1:1], 1'b0};
      psvReq_q    <= rdReq && (rdTarget == TGT_PSV);
      psvAddr_q   <= {rdEa[PSV_ADDR_W-1:1], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sfrWrReq_q   <= 1'b0;
      sfrWrAddr_q  <= '0;
      sfrWrData_q  <= '0;
      sfrWrLanes_q <= 2'b00;
    end else begin
      sfrWrReq_q   <= wrAllowed && (wrTarget == TGT_SFR);
      sfrWrAddr_q  <= {wrEa[SFR_ADDR_W-1:1], 1'b0};
      sfrWrData_q  <= wrWord;
      sfrWrLanes_q <= wrLanes;
    end
  end

  // Second read stage: pick the word source, then the byte.
  always_comb begin
    case (rd1Target_q)
      TGT_RAM:  rd1Result = rd1Word;
      TGT_WREG: rd1Result = rd1WregWord_q;
      TGT_SFR:  rd1Result = sfrRdData;
      TGT_PSV:  rd1Result = psvRdData;
      default:  rd1Result = 16'h0000;
    endcase
    if (rd1Byte_q) begin
      rd1Result = {8'h00, rd1HighByte_q ? rd1Result[15:8] : rd1Result[7:0]};
    end
  end

  // A misaligned read still completes here, using the containing word.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdValid_q <= 1'b0;
      rdData_q  <= 16'h0000;
    end else begin
      rdValid_q <= rd1Valid_q;
      rdData_q  <= rd1Result;
    end
  end

  // The trap comes in the same cycle as the completion of the read, or follows the suppressed store.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addrErrTrap_q <= 1'b0;
      errAddr_q     <= '0;
    end else begin
      addrErrTrap_q <= rd1Misalign_q || (wrReq && wrMisalign);
      if (rd1Misalign_q) begin
        errAddr_q <= rd1Ea_q;
      end else if (wrReq && wrMisalign) begin
        errAddr_q <= wrEa;
      end
    end
  end

  // A new error in the clearing cycle keeps the flag set.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addrErrFlag_q <= 1'b0;
    end else begin
      addrErrFlag_q <= rd1Misalign_q || (wrReq && wrMisalign) ||
                       (addrErrFlag_q && !errClear);
    end
  end

  // Working registers. Later assignments win: stores, pointer updates, loads, extends.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < WREG_N; i++) begin
        wReg_q[i] <= (i == WREG_N - 1) ? WREG15_RESET : WREG_RESET;
      end
    end else begin
      if (wrAllowed && (wrTarget == TGT_WREG)) begin
        if (wrLanes[0]) begin
          wReg_q[wrEa[WIDX_W:1]][7:0] <= wrWord[7:0];
        end
        if (wrLanes[1]) begin
          wReg_q[wrEa[WIDX_W:1]][15:8] <= wrWord[15:8];
        end
      end
      if (wrReq && wrPtrWrite) begin
        wReg_q[wrPtr] <= wrPtrNext;
      end
      if (rdReq && rdPtrWrite) begin
        wReg_q[rdPtr] <= rdPtrNext;
      end
      if (rd1Valid_q) begin
        if (rd1Byte_q) begin
          wReg_q[rd1Dest_q][7:0] <= rd1Result[7:0];
        end else begin
          wReg_q[rd1Dest_q] <= rd1Result;
        end
      end
      if (extReq) begin
        wReg_q[extReg] <= extSigned ?
                          {{8{wReg_q[extReg][7]}}, wReg_q[extReg][7:0]} :
                          {8'h00, wReg_q[extReg][7:0]};
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regView_q <= '0;
    end else begin
      regView_q <= wReg_q[regViewSel];
    end
  end

  // Table access classification into program, nonvolatile store, configuration and other.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tblValid_q <= 1'b0;
      tblKind_q  <= TBL_PROGRAM;
      tblIndex_q <= '0;
    end else begin
      tblValid_q <= tblReq;
      if (tblReq) begin
        tblKind_q  <= (tblAddr <= PROG_SPACE_END) ? TBL_PROGRAM : TBL_OTHER;
        tblIndex_q <= '0;
        if (tblAddr >= NVM_BASE && tblAddr <= NVM_END) begin
          tblKind_q  <= TBL_NVM;
          tblIndex_q <= tblAddr[NVM_IDX_W:1];
        end
        for (int c = 0; c < CFG_N; c++) begin
          if (tblAddr == CFG_ADDR[c]) begin
            tblKind_q  <= TBL_CONFIG;
            tblIndex_q <= NVM_IDX_W'(c);
          end
        end
      end
    end
  end

  // Program addresses keep bit zero clear, so they line up with data addressing.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      progAddr_q <= '0;
    end else if (pcLoad) begin
      progAddr_q <= {pcValue[PC_W-1:1], 1'b0};
    end else if (pcAdvance) begin
      progAddr_q <= progAddr_q + PC_STEP;
    end
  end

endmodule // data_space_access_unit

//--- verif/far_side_model.sv
`timescale 1ns/1ps
module far_side_model
  import data_space_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  sfrRdReq,
  input  wire logic [SFR_ADDR_W-1:0] sfrRdAddr,
  input  wire logic                  psvReq,
  input  wire logic [PSV_ADDR_W-1:0] psvAddr,
  output logic      [WORD_W-1:0]     sfrRdData,
  output logic      [WORD_W-1:0]     psvRdData
);
  logic [WORD_W-1:0] noise_q;

  // Idle buses keep moving, so stale data cannot pass for an answer.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      noise_q <= 16'h0000;
    end else begin
      noise_q <= noise_q + 16'h3C35;
    end
  end

  assign sfrRdData = sfrRdReq ? ({5'h00, sfrRdAddr} ^ 16'h5A00) : noise_q;
  assign psvRdData = psvReq ? ({1'b1, psvAddr} ^ 16'h00FF) : ~noise_q;
endmodule // far_side_model

//--- verif/data_space_access_unit_asserts.sv
`timescale 1ns/1ps
module data_space_access_unit_asserts
  import data_space_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire logic                  rdReq,
  input wire logic                  rdByte,
  input wire agu_mode_e             rdMode,
  input wire logic [EA_W-1:0]       rdDirect,
  input wire logic                  wrReq,
  input wire logic                  wrByte,
  input wire agu_mode_e             wrMode,
  input wire logic [EA_W-1:0]       wrDirect,
  input wire logic                  errClear,
  input wire logic                  tblReq,
  input wire logic [TBL_ADDR_W-1:0] tblAddr,
  input wire logic                  pcAdvance,
  input wire logic                  pcLoad,
  input wire logic                  rdValid_q,
  input wire logic [WORD_W-1:0]     rdData_q,
  input wire logic                  addrErrTrap_q,
  input wire logic                  addrErrFlag_q,
  input wire logic                  sfrWrReq_q,
  input wire logic [1:0]            sfrWrLanes_q,
  input wire logic                  psvReq_q,
  input wire logic [PSV_ADDR_W-1:0] psvAddr_q,
  input wire logic                  tblValid_q,
  input wire tbl_kind_e             tblKind_q,
  input wire logic [NVM_IDX_W-1:0]  tblIndex_q,
  input wire logic [PC_W-1:0]       progAddr_q
);
  logic [EA_W-1:0]       rdDirPrev;
  logic [TBL_ADDR_W-1:0] tblPrev;

  always_ff @(posedge clk) begin
    rdDirPrev <= rdDirect;
    tblPrev   <= tblAddr;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_wrOdd; wrReq && !wrByte && wrMode == AGU_FULL && wrDirect[0]; endsequence
  property p_wrTrap; s_wrOdd |=> addrErrTrap_q; endproperty
  a_wrTrap: assert property (p_wrTrap) else $error("no trap on odd write");
  property p_wrDrop; s_wrOdd |=> !sfrWrReq_q; endproperty
  a_wrDrop: assert property (p_wrDrop) else $error("odd write stored");
  property p_rdTrap;
    rdReq && !rdByte && rdMode == AGU_FULL && rdDirect[0] |-> ##2 (rdValid_q && addrErrTrap_q);
  endproperty
  a_rdTrap: assert property (p_rdTrap) else $error("odd read misbehaved");
  property p_byteZero; rdReq && rdByte |-> ##2 (rdValid_q && rdData_q[15:8] == 8'h00); endproperty
  a_byteZero: assert property (p_byteZero) else $error("byte read upper bits");
  property p_window;
    rdReq && rdMode == AGU_FULL && rdDirect[15] |=> psvReq_q && psvAddr_q == {rdDirPrev[14:1], 1'b0};
  endproperty
  a_window: assert property (p_window) else $error("window read lost");
  property p_near; rdReq && rdMode == AGU_NEAR |=> !psvReq_q; endproperty
  a_near: assert property (p_near) else $error("near read hit window");
  property p_sticky; addrErrFlag_q && !errClear |=> addrErrFlag_q; endproperty
  a_sticky: assert property (p_sticky) else $error("error flag dropped");
  property p_lane;
    wrReq && wrByte && wrMode == AGU_FULL && wrDirect[0] |=> !sfrWrReq_q || sfrWrLanes_q == 2'b10;
  endproperty
  a_lane: assert property (p_lane) else $error("wrong byte lane");
  property p_cfg;
    tblReq && tblAddr == 24'hF8000E |=> tblValid_q && tblKind_q == TBL_CONFIG && tblIndex_q == 8'h06;
  endproperty
  a_cfg: assert property (p_cfg) else $error("config word index");
  property p_nvm;
    tblReq && tblAddr[23:9] == 15'h3FFF |=> tblKind_q == TBL_NVM && tblIndex_q == tblPrev[8:1];
  endproperty
  a_nvm: assert property (p_nvm) else $error("data store index");
  property p_pc; pcAdvance && !pcLoad |=> progAddr_q == $past(progAddr_q) + 23'h000002; endproperty
  a_pc: assert property (p_pc) else $error("program step");
endmodule // data_space_access_unit_asserts

bind data_space_access_unit data_space_access_unit_asserts u_data_space_access_unit_asserts (
  .clk, .reset_n, .rdReq, .rdByte, .rdMode, .rdDirect, .wrReq, .wrByte, .wrMode, .wrDirect,
  .errClear, .tblReq, .tblAddr, .pcAdvance, .pcLoad, .rdValid_q, .rdData_q, .addrErrTrap_q,
  .addrErrFlag_q, .sfrWrReq_q, .sfrWrLanes_q, .psvReq_q, .psvAddr_q, .tblValid_q, .tblKind_q,
  .tblIndex_q, .progAddr_q);

//--- verif/data_space_access_unit_test.sv
`timescale 1ns/1ps
module data_space_access_unit_test;
  import data_space_pkg::*;
  logic clk, reset_n, rdReq, rdByte, wrReq, wrByte, extReq, extSigned, errClear, tblReq;
  logic pcAdvance, pcLoad, rdValid_q, addrErrTrap_q, addrErrFlag_q, sfrRdReq_q, sfrWrReq_q;
  logic psvReq_q, tblValid_q;
  agu_mode_e rdMode, wrMode;
  tbl_kind_e tblKind_q;
  logic [WIDX_W-1:0] rdPtr, rdDest, wrPtr, extReg, regViewSel;
  logic [EA_W-1:0] rdDirect, wrDirect, errAddr_q;
  logic [WORD_W-1:0] wrData, sfrRdData, psvRdData, rdData_q, sfrWrData_q, regView_q;
  logic [SFR_ADDR_W-1:0] sfrRdAddr_q, sfrWrAddr_q;
  logic [PSV_ADDR_W-1:0] psvAddr_q;
  logic [TBL_ADDR_W-1:0] tblAddr;
  logic [PC_W-1:0] pcValue, progAddr_q;
  logic [NVM_IDX_W-1:0] tblIndex_q;
  logic [1:0] sfrWrLanes_q;
  int errors, num_checks;

  data_space_access_unit #(.BIG_VARIANT(1'b1)) u_data_space_access_unit (
    .clk, .reset_n, .rdReq, .rdByte, .rdMode, .rdPtr, .rdDirect, .rdDest, .wrReq, .wrByte,
    .wrMode, .wrPtr, .wrDirect, .wrData, .extReq, .extSigned, .extReg, .errClear, .sfrRdData,
    .psvRdData, .tblReq, .tblAddr, .pcAdvance, .pcLoad, .pcValue, .regViewSel, .rdValid_q,
    .rdData_q, .addrErrTrap_q, .addrErrFlag_q, .errAddr_q, .sfrRdReq_q, .sfrRdAddr_q,
    .sfrWrReq_q, .sfrWrAddr_q, .sfrWrData_q, .sfrWrLanes_q, .psvReq_q, .psvAddr_q,
    .tblValid_q, .tblKind_q, .tblIndex_q, .progAddr_q, .regView_q);

  far_side_model u_far_side_model (.clk, .reset_n, .sfrRdReq(sfrRdReq_q),
    .sfrRdAddr(sfrRdAddr_q), .psvReq(psvReq_q), .psvAddr(psvAddr_q), .sfrRdData, .psvRdData);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string n, input logic [23:0] g, input logic [23:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_sim();
    $display("Counts: %0d compares, %0d mismatches", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr(input agu_mode_e m, input logic [3:0] p, input logic [15:0] a, d,
                    input logic b);
    @(posedge clk);
    wrMode <= m;
    {wrReq, wrByte, wrPtr, wrDirect, wrData} <= {1'b1, b, p, a, d};
    @(posedge clk);
    wrReq <= 1'b0;
  endtask

  // The result stands for one cycle only, so it is sampled mid-cycle.
  task automatic rd(input agu_mode_e m, input logic [3:0] p, input logic [15:0] a,
                    input logic b, input logic [3:0] d, input logic [15:0] e);
    @(posedge clk);
    rdMode <= m;
    {rdReq, rdByte, rdPtr, rdDirect, rdDest} <= {1'b1, b, p, a, d};
    @(posedge clk);
    rdReq <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("rdValid", rdValid_q, 1'b1);
    chk("rdData", rdData_q, e);
  endtask

  task automatic view(input logic [3:0] r, input logic [15:0] e);
    @(posedge clk);
    regViewSel <= r;
    @(posedge clk);
    @(negedge clk);
    chk("regView", regView_q, e);
  endtask

  task automatic ext(input logic s, input logic [3:0] r);
    @(posedge clk);
    {extReq, extSigned, extReg} <= {1'b1, s, r};
    @(posedge clk);
    extReq <= 1'b0;
  endtask

  task automatic tbl(input logic [23:0] a, input tbl_kind_e k, input logic [7:0] i);
    @(posedge clk);
    {tblReq, tblAddr} <= {1'b1, a};
    @(posedge clk);
    tblReq <= 1'b0;
    @(negedge clk);
    chk("tblValid", tblValid_q, 1'b1);
    chk("tblKind", tblKind_q, k);
    if (k inside {TBL_NVM, TBL_CONFIG}) chk("tblIndex", tblIndex_q, i);
  endtask

  task automatic t_ram();
    view(4'hF, 16'h0800);
    wr(AGU_FULL, 0, 16'h0802, 16'h1234, 0);
    wr(AGU_FULL, 0, 16'h0803, 16'h00AB, 1);
    rd(AGU_FULL, 0, 16'h0802, 0, 4'hD, 16'hAB34);
    rd(AGU_FULL, 0, 16'h0803, 1, 4'hD, 16'h00AB);
    rd(AGU_FULL, 0, 16'h0802, 1, 4'hD, 16'h0034);
    wr(AGU_FULL, 0, 16'h0101, 16'h00CD, 1);
    @(negedge clk);
    chk("sfrWrReq", sfrWrReq_q, 1'b1);
    chk("sfrWrLanes", sfrWrLanes_q, 2'b10);
    chk("sfrWrAddr", sfrWrAddr_q, 11'h100);
    chk("sfrWrData", sfrWrData_q, 16'hCDCD);
    wr(AGU_FULL, 0, 16'h0002, 16'h5A5A, 0);
    rd(AGU_FULL, 0, 16'h0803, 1, 4'h1, 16'h00AB);
    view(4'h1, 16'h5AAB);
    ext(1'b1, 4'h1);
    view(4'h1, 16'hFFAB);
    ext(1'b0, 4'h1);
    view(4'h1, 16'h00AB);
    $display("test ram done");
  endtask

  task automatic t_agu();
    wr(AGU_FULL, 0, 16'h0008, 16'h0802, 0);
    rd(AGU_POSTINC, 4'h4, 0, 1, 4'hD, 16'h0034);
    view(4'h4, 16'h0803);
    wr(AGU_FULL, 0, 16'h000C, 16'h0820, 0);
    wr(AGU_POSTINC, 4'h6, 0, 16'h7777, 0);
    view(4'h6, 16'h0822);
    wr(AGU_FULL, 0, 16'h0008, 16'h0820, 0);
    rd(AGU_POSTINC, 4'h4, 0, 0, 4'hD, 16'h7777);
    view(4'h4, 16'h0822);
    wr(AGU_INDIRECT, 4'h6, 0, 16'h6666, 0);
    rd(AGU_INDIRECT, 4'h4, 0, 0, 4'hD, 16'h6666);
    // Read and write taken at the same edge must not disturb each other.
    @(posedge clk);
    {rdMode, wrMode} <= {AGU_FULL, AGU_FULL};
    {wrReq, wrByte, wrDirect, wrData} <= {2'b10, 16'h0810, 16'h5555};
    {rdReq, rdByte, rdDirect, rdDest} <= {2'b10, 16'h0802, 4'hD};
    @(posedge clk);
    {wrReq, rdReq} <= 2'b00;
    @(posedge clk);
    @(negedge clk);
    chk("rdData", rdData_q, 16'hAB34);
    rd(AGU_FULL, 0, 16'h0810, 0, 4'hD, 16'h5555);
    $display("test agu done");
  endtask

  task automatic t_map();
    wr(AGU_FULL, 0, 16'h0FFE, 16'hC3C3, 0);
    rd(AGU_FULL, 0, 16'h0FFE, 0, 4'hD, 16'hC3C3);
    rd(AGU_FULL, 0, 16'h1000, 0, 4'hD, 16'h0000);
    rd(AGU_FULL, 0, 16'h00C0, 0, 4'hD, 16'h0000);
    rd(AGU_FULL, 0, 16'h0100, 0, 4'hD, 16'h5B00);
    rd(AGU_NEAR, 0, 16'h8802, 0, 4'hD, 16'hAB34);
    rd(AGU_FULL, 0, 16'h8802, 0, 4'hD, 16'h88FD);
    $display("test map done");
  endtask

  task automatic t_err();
    wr(AGU_FULL, 0, 16'h0811, 16'h9999, 0);
    @(negedge clk);
    chk("trap", addrErrTrap_q, 1'b1);
    @(negedge clk);
    chk("flag", addrErrFlag_q, 1'b1);
    chk("errAddr", errAddr_q, 16'h0811);
    rd(AGU_FULL, 0, 16'h0810, 0, 4'hD, 16'h5555);
    rd(AGU_FULL, 0, 16'h0803, 0, 4'hD, 16'hAB34);
    chk("trap", addrErrTrap_q, 1'b1);
    @(posedge clk);
    errClear <= 1'b1;
    @(posedge clk);
    errClear <= 1'b0;
    @(negedge clk);
    chk("flag", addrErrFlag_q, 1'b0);
    $display("test err done");
  endtask

  task automatic t_tbl();
    for (int i = 0; i < 7; i++) begin
      tbl(i == 0 ? 24'hF80000 : 24'hF80002 + 24'(2 * i), TBL_CONFIG, 8'(i));
    end
    tbl(24'hF80002, TBL_OTHER, 8'h00);
    tbl(24'h7FFE00, TBL_NVM, 8'h00);
    tbl(24'h7FFFFE, TBL_NVM, 8'hFF);
    tbl(24'h000100, TBL_PROGRAM, 8'h00);
    @(posedge clk);
    {pcLoad, pcValue} <= {1'b1, 23'h000100};
    @(posedge clk);
    {pcLoad, pcAdvance} <= 2'b01;
    repeat (2) @(posedge clk);
    pcAdvance <= 1'b0;
    @(negedge clk);
    chk("progAddr", progAddr_q, 23'h000104);
    $display("test table done");
  endtask

  initial begin
    {rdReq, rdByte, wrReq, wrByte, extReq, extSigned, errClear, tblReq, pcAdvance, pcLoad} = '0;
    {rdPtr, rdDest, wrPtr, extReg, regViewSel, rdDirect, wrDirect, wrData, tblAddr, pcValue} = '0;
    rdMode = AGU_INDIRECT;
    wrMode = AGU_INDIRECT;
    reset_n = 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_ram();
    t_agu();
    t_map();
    t_err();
    t_tbl();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("Watchdog expired");
    end_sim();
  end
endmodule // data_space_access_unit_test
